/* shared/position_counter_defines.vh */
`ifndef POSITION_COUNTER_DEFINES_VH
`define POSITION_COUNTER_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_POSITION_CONTROL 4'h0
`define OFS_WRAP_PERIOD 4'h4
`define OFS_COMPARE_VALUE 4'h8
`define OFS_COUNT_CAPTURE 4'hC

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define CTL_MODE_HI 18
`define CTL_MODE_LO 17
`define CTL_THREE_PHASE 16
`define CTL_MATCH_FLAG 15
`define CTL_REVERSE_ERR 14
`define CTL_DIRECTION 13
`define CTL_INDEX_DET 12
`define CTL_SOFT_CAPTURE 11
`define CTL_COUNT_CLEAR 10
`define CTL_INDEX_EDGE 9
`define CTL_CMP_EN 8
`define CTL_INDEX_EN 7
`define CTL_RUN 6
`define CTL_FILT_HI 5
`define CTL_FILT_LO 4
`define CTL_IRQ_EN 3
`define CTL_DIV_HI 2
`define CTL_DIV_LO 0

// ----------------------------------------------------------------
// Modes, reset values, filter widths in system clock periods
// ----------------------------------------------------------------
`define MODE_ENCODER 2'h0
`define MODE_SENSOR_EVENT 2'h1
`define MODE_SENSOR_TIMER 2'h2
`define MODE_TIMER 2'h3
`define RST_ZERO32 32'h00000000
`define FILT_CYC_01 7'h1F
`define FILT_CYC_10 7'h3F
`define FILT_CYC_11 7'h7F
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* design/quadrature_hall_position_counter.v */
// What this block does
// - Interrupt raised only with interrupt enable set
// - Filter selector: bypass, 31, 63, 127 cycles
// - Count pulse divided by 1 to 128
// - Mode field picks four modes, eight configs
// - Stopping holds counter; only clear zeroes it
// - Match and reverse flags: read-clear, zero stopped
// - Index flag and direction forced zero stopped
// - Encoder counter wraps at wrap period
// - 16-bit compare match in encoder/event modes
// - Encoder index mode: match irq waits for index
// - Sensor timer compare flags abnormal interval
// - Timer mode 24-bit compare sets match
// - Upper compare bits only in timer modes
// - Event mode counts up/down with wrap
// - Sensor timer counts clocks, captures per pulse
// - Timer counts clocks, captures on index edge
// - Capture cleared by reset or clear+capture
// - Upper count bits read zero in 16-bit modes
// - Direction reads one clockwise, zero otherwise
// - Counter clear write zeroes counter, reads zero
// - Software capture only in timer-type modes
`include "position_counter_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module quadrature_hall_position_counter (
    input wire clk,
    input wire arst_n,
    input wire ce,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [3:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    output reg [1:0] s_axi_bresp,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    input wire [3:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    input wire sense_a,
    input wire sense_b,
    input wire sense_z,
    output reg position_irq,
    output reg event_pulse
);

    // ------------------------------------------------------------
    // Input synchronisers and noise filters
    // ------------------------------------------------------------
    wire [2:0] pin_in;
    reg [2:0] sync1_q;
    reg [2:0] sync2_q;
    wire [2:0] filt;
    reg [1:0] filter_width_sel_q;
    reg [6:0] filt_lim;

    assign pin_in = {sense_z, sense_b, sense_a};

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
        end else if (ce) begin
            sync1_q <= pin_in;
            sync2_q <= sync1_q;
        end
    end

    always @* begin
        case (filter_width_sel_q)
            2'h1: filt_lim = `FILT_CYC_01;
            2'h2: filt_lim = `FILT_CYC_10;
            default: filt_lim = `FILT_CYC_11;
        endcase
    end

    // Filter keeps counting while stopped so the level is always clean
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_filt
            reg [6:0] cnt_q;
            reg lvl_q;
            always @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    cnt_q <= 7'h00;
                    lvl_q <= 1'b0;
                end else if (ce) begin
                    if (filter_width_sel_q == 2'h0) begin
                        lvl_q <= sync2_q[gi];
                        cnt_q <= 7'h00;
                    end else if (sync2_q[gi] == lvl_q) begin
                        cnt_q <= 7'h00;
                    end else if (cnt_q + 7'h01 >= filt_lim) begin
                        lvl_q <= sync2_q[gi];
                        cnt_q <= 7'h00;
                    end else begin
                        cnt_q <= cnt_q + 7'h01;
                    end
                end
            end
            assign filt[gi] = lvl_q;
        end
    endgenerate

    // ------------------------------------------------------------
    // Control state
    // ------------------------------------------------------------
    reg [1:0] mode_q;
    reg three_phase_sel_q;
    reg match_q;
    reg reverr_q;
    reg direction_bit_q;
    reg index_det_q;
    reg index_edge_q;
    reg cmp_en_q;
    reg index_en_q;
    reg run_q;
    reg irq_en_q;
    reg [2:0] div_sel_q;
    reg [15:0] wrap_period_q;
    reg [23:0] compare_q;
    reg [23:0] counter_q;
    reg [23:0] capture_q;
    reg [6:0] div_cnt_q;
    reg [2:0] prev_q;
    reg dir_seen_q;
    reg match_prev_q;

    // ------------------------------------------------------------
    // Edge decode and direction
    // ------------------------------------------------------------
    function [2:0] hall_idx;
        input [2:0] s;
        begin
            case (s)
                3'h1: hall_idx = 3'h0;
                3'h3: hall_idx = 3'h1;
                3'h2: hall_idx = 3'h2;
                3'h6: hall_idx = 3'h3;
                3'h4: hall_idx = 3'h4;
                3'h5: hall_idx = 3'h5;
                default: hall_idx = 3'h7;
            endcase
        end
    endfunction

    reg quad_count_pulse;
    reg pulse_cw;
    reg [2:0] idx_now;
    reg [2:0] idx_old;
    reg z_rise;
    reg z_fall;
    reg z_enc_edge;
    reg z_tmr_edge;
    reg index_hit;
    reg index_clear;
    wire timer_type;

    assign timer_type = (mode_q == `MODE_SENSOR_TIMER) || (mode_q == `MODE_TIMER);

    always @* begin
        idx_now = hall_idx(filt);
        idx_old = hall_idx(prev_q);
        quad_count_pulse = 1'b0;
        pulse_cw = 1'b0;
        if (three_phase_sel_q) begin
            // Six edges per electrical turn from the three Hall lines
            if (idx_now != 3'h7 && idx_old != 3'h7 && idx_now != idx_old) begin
                quad_count_pulse = 1'b1;
                pulse_cw = (idx_now == ((idx_old == 3'h5) ? 3'h0 : idx_old + 3'h1));
            end
        end else if ((filt[0] ^ prev_q[0]) ^ (filt[1] ^ prev_q[1])) begin
            quad_count_pulse = 1'b1;
            pulse_cw = prev_q[1] ^ filt[0];
        end
        if (!run_q || mode_q == `MODE_TIMER) begin
            quad_count_pulse = 1'b0;
        end
        z_rise = filt[2] & ~prev_q[2];
        z_fall = ~filt[2] & prev_q[2];
        z_enc_edge = (mode_q == `MODE_ENCODER) && run_q &&
                     (direction_bit_q ? z_rise : z_fall);
        z_tmr_edge = (mode_q == `MODE_TIMER) && run_q && (index_edge_q ? z_fall : z_rise);
        index_hit = z_enc_edge || z_tmr_edge;
        index_clear = index_hit && index_en_q;
    end

    // ------------------------------------------------------------
    // Compare
    // ------------------------------------------------------------
    reg match_now;
    reg [23:0] cmp_mask;

    always @* begin
        cmp_mask = timer_type ? 24'hFFFFFF : 24'h00FFFF;
        match_now = run_q && cmp_en_q &&
                    ((counter_q & cmp_mask) == (compare_q & cmp_mask));
    end

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    reg [3:0] waddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    wire do_write;
    wire wr_ctl;
    wire rd_take;
    wire rd_ctl;
    wire soft_clear;
    wire soft_capture;

    assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign wr_ctl = do_write && (waddr_q == `OFS_POSITION_CONTROL) && (wstrb_q == 4'hF);
    assign rd_take = s_axi_arvalid && s_axi_arready;
    assign rd_ctl = rd_take && (s_axi_araddr == `OFS_POSITION_CONTROL);
    assign soft_clear = wr_ctl && wdata_q[`CTL_COUNT_CLEAR];
    assign soft_capture = wr_ctl && wdata_q[`CTL_SOFT_CAPTURE] && timer_type;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= `RST_ZERO32;
            s_axi_rresp <= `RESP_OKAY;
            waddr_q <= 4'h0;
            wdata_q <= `RST_ZERO32;
            wstrb_q <= 4'h0;
            mode_q <= `MODE_ENCODER;
            three_phase_sel_q <= 1'b0;
            index_edge_q <= 1'b0;
            cmp_en_q <= 1'b0;
            index_en_q <= 1'b0;
            run_q <= 1'b0;
            filter_width_sel_q <= 2'h0;
            irq_en_q <= 1'b0;
            div_sel_q <= 3'h0;
            wrap_period_q <= 16'h0000;
            compare_q <= 24'h000000;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                waddr_q <= {s_axi_awaddr[3:2], 2'h0};
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `RESP_OKAY;
                // Partial-word writes are dropped to keep fields coherent
                if (wstrb_q == 4'hF) begin
                    case (waddr_q)
                        `OFS_POSITION_CONTROL: begin
                            mode_q <= wdata_q[`CTL_MODE_HI:`CTL_MODE_LO];
                            three_phase_sel_q <= wdata_q[`CTL_THREE_PHASE];
                            index_edge_q <= wdata_q[`CTL_INDEX_EDGE];
                            cmp_en_q <= wdata_q[`CTL_CMP_EN];
                            index_en_q <= wdata_q[`CTL_INDEX_EN];
                            run_q <= wdata_q[`CTL_RUN];
                            filter_width_sel_q <= wdata_q[`CTL_FILT_HI:`CTL_FILT_LO];
                            irq_en_q <= wdata_q[`CTL_IRQ_EN];
                            div_sel_q <= wdata_q[`CTL_DIV_HI:`CTL_DIV_LO];
                        end
                        `OFS_WRAP_PERIOD: wrap_period_q <= wdata_q[15:0];
                        `OFS_COMPARE_VALUE: compare_q <= wdata_q[23:0];
                        default: ;
                    endcase
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
            if (rd_take) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `RESP_OKAY;
                case ({s_axi_araddr[3:2], 2'h0})
                    `OFS_POSITION_CONTROL:
                        s_axi_rdata <= {13'h0000, mode_q, three_phase_sel_q, match_q,
                                        reverr_q, direction_bit_q, index_det_q, 2'h0,
                                        index_edge_q, cmp_en_q, index_en_q, run_q,
                                        filter_width_sel_q, irq_en_q, div_sel_q};
                    `OFS_WRAP_PERIOD: s_axi_rdata <= {16'h0000, wrap_period_q};
                    `OFS_COMPARE_VALUE: s_axi_rdata <= {8'h00, compare_q};
                    default:
                        s_axi_rdata <= timer_type ? {8'h00, capture_q} :
                                       {16'h0000, counter_q[15:0]};
                endcase
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Counter, capture, flags, divider, interrupt
    // ------------------------------------------------------------
    wire div_fire;
    wire match_evt;
    wire match_irq_ok;
    reg [6:0] div_reload;

    always @* begin
        div_reload = 7'h00;
        case (div_sel_q)
            3'h0: div_reload = 7'h00;
            3'h1: div_reload = 7'h01;
            3'h2: div_reload = 7'h03;
            3'h3: div_reload = 7'h07;
            3'h4: div_reload = 7'h0F;
            3'h5: div_reload = 7'h1F;
            3'h6: div_reload = 7'h3F;
            default: div_reload = 7'h7F;
        endcase
    end

    assign div_fire = quad_count_pulse && (div_cnt_q == 7'h00);
    assign match_evt = match_now && !match_prev_q;
    assign match_irq_ok = !((mode_q == `MODE_ENCODER) && index_en_q && !index_det_q);

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            counter_q <= 24'h000000;
            capture_q <= 24'h000000;
            div_cnt_q <= 7'h00;
            prev_q <= 3'h0;
            match_q <= 1'b0;
            reverr_q <= 1'b0;
            direction_bit_q <= 1'b0;
            index_det_q <= 1'b0;
            dir_seen_q <= 1'b0;
            match_prev_q <= 1'b0;
            position_irq <= 1'b0;
            event_pulse <= 1'b0;
        end else if (ce) begin
            prev_q <= filt;
            match_prev_q <= match_now;
            event_pulse <= div_fire;
            position_irq <= irq_en_q && (div_fire || (match_evt && match_irq_ok));
            // Counter: software clear beats index clear beats counting
            if (soft_clear) begin
                counter_q <= 24'h000000;
            end else if (!run_q) begin
                counter_q <= counter_q;
            end else if (index_clear) begin
                counter_q <= 24'h000000;
            end else begin
                case (mode_q)
                    `MODE_ENCODER: begin
                        if (quad_count_pulse && pulse_cw) begin
                            counter_q <= (counter_q[15:0] == wrap_period_q) ? 24'h000000 :
                                         {8'h00, counter_q[15:0] + 16'h0001};
                        end else if (quad_count_pulse) begin
                            counter_q <= (counter_q[15:0] == 16'h0000) ? {8'h00, wrap_period_q} :
                                         {8'h00, counter_q[15:0] - 16'h0001};
                        end
                    end
                    `MODE_SENSOR_EVENT: begin
                        if (quad_count_pulse) begin
                            counter_q <= {8'h00, pulse_cw ? counter_q[15:0] + 16'h0001 :
                                          counter_q[15:0] - 16'h0001};
                        end
                    end
                    `MODE_SENSOR_TIMER: begin
                        counter_q <= quad_count_pulse ? 24'h000000 :
                                     counter_q + 24'h000001;
                    end
                    default: counter_q <= counter_q + 24'h000001;
                endcase
            end
            // Capture survives stop; only reset or clear-then-capture zeroes it
            if (soft_capture) begin
                capture_q <= soft_clear ? 24'h000000 : counter_q;
            end else if (run_q && mode_q == `MODE_SENSOR_TIMER && quad_count_pulse) begin
                capture_q <= counter_q;
            end else if (index_clear && mode_q == `MODE_TIMER) begin
                capture_q <= counter_q;
            end
            if (!run_q) begin
                div_cnt_q <= 7'h00;
                match_q <= 1'b0;
                reverr_q <= 1'b0;
                direction_bit_q <= 1'b0;
                index_det_q <= 1'b0;
                dir_seen_q <= 1'b0;
            end else begin
                if (quad_count_pulse) begin
                    div_cnt_q <= div_fire ? div_reload : div_cnt_q - 7'h01;
                    direction_bit_q <= pulse_cw;
                    dir_seen_q <= 1'b1;
                end
                // Hardware set wins over the read clear; set once per arrival
                if (match_evt) begin
                    match_q <= 1'b1;
                end else if (rd_ctl) begin
                    match_q <= 1'b0;
                end
                if (quad_count_pulse && mode_q == `MODE_SENSOR_TIMER && dir_seen_q &&
                    pulse_cw != direction_bit_q) begin
                    reverr_q <= 1'b1;
                end else if (rd_ctl) begin
                    reverr_q <= 1'b0;
                end
                if (index_hit) begin
                    index_det_q <= 1'b1;
                end
            end
        end
    end

endmodule // quadrature_hall_position_counter

`default_nettype wire

/* tb/pos_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module pos_chk (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata
);
    // ------------------------------------------------------------
    // Register bus handshake
    // ------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    a_b_okay: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0)
        else $error("write response not okay");
    a_w_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write channel open during response");
    a_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address open during response");
    a_rd_answer: assert property (ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_wr_answer: assert property (ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    a_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read response not released");
endmodule // pos_chk

bind quadrature_hall_position_counter pos_chk u_chk (.clk(clk), .arst_n(arst_n), .ce(ce),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));
`default_nettype wire

/* tb/encoder_model.sv */
`timescale 1ns/1ps
`default_nettype none
module encoder_model (
    input wire logic clk,
    output logic a,
    output logic b,
    output logic z
);
    // ------------------------------------------------------------
    // Quadrature source, A leads B when clockwise
    // ------------------------------------------------------------
    logic [1:0] ph = 2'h0;
    initial begin
        a = 1'b0;
        b = 1'b0;
        z = 1'b0;
    end
    task automatic step(input bit cw, input int hold);
        @(posedge clk);
        ph = cw ? ph + 2'h1 : ph - 2'h1;
        a <= ph[1] ^ ph[0];
        b <= ph[1];
        repeat (hold) @(posedge clk);
    endtask
    // Short spike on A, shorter than the narrowest filter
    task automatic glitch(input int len);
        @(posedge clk);
        a <= ~a;
        repeat (len) @(posedge clk);
        a <= ~a;
        repeat (40) @(posedge clk);
    endtask
endmodule // encoder_model
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk, arst_n, awvalid, wvalid, bready, arvalid, rready;
    logic [3:0] awaddr, araddr;
    logic [31:0] wdata;
    wire awready, wready, bvalid, arready, rvalid, irq, evp, sa, sb, sz;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    int mismatches = 0;
    int cmp_count = 0;
    int irq_n = 0;
    int ev_n = 0;
    int i0, e0;
    logic [3:0] ra [5] = '{4'h4, 4'h8, 4'hC, 4'h0, 4'h0};
    logic [31:0] rw [5] = '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'h12345678, 32'h0005FFBF, 32'h0};
    logic [31:0] rx [5] = '{32'h0000FFFF, 32'h00FFFFFF, 32'h0, 32'h000503BF, 32'h0};

    quadrature_hall_position_counter u_dut (.clk(clk), .arst_n(arst_n), .ce(1'b1),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .sense_a(sa), .sense_b(sb), .sense_z(sz),
        .position_irq(irq), .event_pulse(evp));
    encoder_model u_enc (.clk(clk), .a(sa), .b(sb), .z(sz));

    // ------------------------------------------------------------
    // Clock, pulse counters, bus tasks
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        if (irq === 1'b1) irq_n++;
        if (evp === 1'b1) ev_n++;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] ad, input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        awvalid <= 1'b1; awaddr <= ad; wvalid <= 1'b1; wdata <= d; bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 1000);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] ad, input logic [31:0] exp);
        int n = 0;
        @(posedge clk);
        arvalid <= 1'b1; araddr <= ad; rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 1000);
        rready <= 1'b0;
        chk(rdata, exp);
        chk({30'h0, rresp}, 32'h0);
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #2000000;
        mismatches++;
        tally_and_finish();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        arst_n = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
        arvalid = 1'b0; rready = 1'b0; awaddr = 4'h0; araddr = 4'h0; wdata = 32'h0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        for (int k = 0; k < 5; k++) begin
            wr(ra[k], rw[k]);
            rd(ra[k], rx[k]);
        end
        $display("test register rows done");
        wr(4'h4, 32'h3);
        wr(4'h0, 32'h48);
        i0 = irq_n;
        e0 = ev_n;
        repeat (5) u_enc.step(1'b1, 8);
        rd(4'hC, 32'h1);
        rd(4'h0, 32'h2048);
        repeat (2) u_enc.step(1'b0, 8);
        rd(4'hC, 32'h3);
        rd(4'h0, 32'h48);
        chk(irq_n - i0, 7);
        wr(4'h0, 32'h08);
        rd(4'hC, 32'h3);
        rd(4'h0, 32'h08);
        wr(4'h0, 32'h408);
        rd(4'hC, 32'h0);
        $display("test encoder wrap done");
        i0 = irq_n;
        e0 = ev_n;
        wr(4'h0, 32'h42);
        repeat (8) u_enc.step(1'b1, 8);
        chk(ev_n - e0, 2);
        chk(irq_n - i0, 0);
        wr(4'h0, 32'h50);
        e0 = ev_n;
        u_enc.glitch(20);
        u_enc.step(1'b1, 60);
        chk(ev_n - e0, 1);
        $display("test divider and filter done");
        wr(4'h8, 32'h2);
        wr(4'h0, 32'h548);
        repeat (2) u_enc.step(1'b1, 8);
        rd(4'h0, 32'hA148);
        rd(4'h0, 32'h2148);
        wr(4'h0, 32'h60400);
        wr(4'h8, 32'h100);
        i0 = irq_n;
        wr(4'h0, 32'h60148);
        repeat (300) @(posedge clk);
        rd(4'h0, 32'h68148);
        rd(4'h0, 32'h60148);
        chk(irq_n - i0, 1);
        $display("test compare done");
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        for (int k = 0; k < 4; k++) rd(4'(4 * k), 32'h0);
        $display("test reset values done");
        tally_and_finish();
    end
endmodule // tb
`default_nettype wire
